/* File: hdl/ebi_pkg.sv */
package ebi_pkg;

   localparam int EBI_ADDR_W      = 25;
   localparam int EBI_AREAS       = 6;
   localparam int EBI_WAIT_W      = 3;
   localparam int EBI_BLOCK_SHIFT = 16;
   localparam int EBI_AREA_BASE_W = EBI_ADDR_W - EBI_BLOCK_SHIFT;
   localparam int EBI_BASIC_CYC   = 2;
   localparam int EBI_CLK_DIV     = 2;
   localparam int EBI_SYNC_STAGES = 2;
   localparam logic [EBI_WAIT_W-1:0] EBI_WAIT_MAX = 3'h7;

   typedef struct packed
   {
      logic [EBI_AREA_BASE_W-1:0] base;
      logic [EBI_AREA_BASE_W-1:0] mask;
      logic [EBI_WAIT_W-1:0]      waits;
   } ebi_area_cfg_t;

   typedef struct packed
   {
      logic                  wr;
      logic                  half;
      logic                  byte_hi;
      logic [EBI_ADDR_W-1:0] addr;
      logic [15:0]           wdata;
   } ebi_req_t;

   typedef enum logic [1:0]
   {
      EBI_WIDTH_8  = 2'h0,
      EBI_WIDTH_16 = 2'h1
   } ebi_width_t;

endpackage

/* File: hdl/ebi_clk_div.sv */
// Bus-rate enable and external clock from the internal clock
module ebi_clk_div
   import ebi_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   output logic      bus_en_o,
   output logic      bus_clk_o
);

   logic phase_r;

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         phase_r   <= 1'b0;
         bus_en_o  <= 1'b0;
         bus_clk_o <= 1'b0;
      end
      else
      begin
         phase_r   <= ~phase_r;
         bus_en_o  <= phase_r;
         bus_clk_o <= ~phase_r;
      end
   end

endmodule

/* File: hdl/ebi_top.sv */
// What this block does
// - Unwaited access lasts two bus clock cycles.
// - Each area adds zero to seven wait cycles to every access.
// - A 25-bit byte address is driven on the address pins.
// - Six select outputs decode areas of 64 KB granularity.
// - In 16-bit mode, little-endian byte swap applies to one chosen area among one to five.
// - In 8-bit mode upper data pins become general ports.
// - Unneeded upper address pins can become general ports.
// - Access stretches while ready input is low.
// - Grant output low while bus released, high otherwise.
// - Upper strobe for high byte, lower strobe for low byte; 8-bit uses upper only.
// - Lower strobe pin floats during reset.
// - Bus runs at half internal clock.
// - Clock pin outputs bus clock unless used as port.
// - Select low marks access to its area; unused selects become ports.
module ebi_top
   import ebi_pkg::*;
(
   input  wire logic                  sys_clk_i,
   input  wire logic                  rstn_i,
   input  wire logic                  req_valid_i,
   input  wire ebi_req_t              req_i,
   output logic                       req_ready_o,
   output logic                       rsp_valid_o,
   output logic [15:0]                rsp_data_o,
   input  wire ebi_area_cfg_t         area_cfg_i [EBI_AREAS],
   input  wire logic [EBI_AREAS-1:0]  area_en_i,
   input  wire logic [2:0]            le_area_i,
   input  wire logic                  le_en_i,
   input  wire ebi_width_t            width_i,
   input  wire logic [7:0]            addr_port_sel_i,
   input  wire logic [7:0]            addr_port_out_i,
   input  wire logic [7:0]            data_port_out_i,
   input  wire logic [7:0]            data_port_oe_i,
   input  wire logic                  clk_port_sel_i,
   input  wire logic                  clk_port_out_i,
   input  wire logic                  lstrb_port_out_i,
   input  wire logic                  lstrb_port_oe_i,
   input  wire logic [EBI_AREAS-1:0]  sel_port_sel_i,
   input  wire logic [EBI_AREAS-1:0]  sel_port_out_i,
   output logic [EBI_ADDR_W-1:0]      addr_o,
   output logic [EBI_ADDR_W-1:0]      addr_oe_o,
   input  wire logic [15:0]           data_i,
   output logic [15:0]                data_o,
   output logic [15:0]                data_oe_o,
   output logic [7:0]                 upper_data_port_pins_o,
   output logic [EBI_AREAS-1:0]       area_select_n_o,
   output logic [EBI_AREAS-1:0]       area_select_oe_o,
   output logic                       read_strobe_n_o,
   output logic                       rd_oe_o,
   output logic                       upper_lane_write_strobe_n_o,
   output logic                       upper_lane_oe_o,
   output logic                       lower_lane_write_strobe_n_o,
   output logic                       lower_lane_oe_o,
   output logic                       bus_clk_o,
   input  wire logic                  ready_i,
   input  wire logic                  bus_release_request_i,
   output logic                       bus_release_grant_o
);

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {EBI_IDLE, EBI_ADDR, EBI_DATA, EBI_GRANT} ebi_state_t;

   ebi_state_t                 state_r;
   ebi_state_t                 state_nxt;
   logic                       bus_en;
   logic                       div_clk;
   logic [1:0]                 rdy_sync_r;
   logic [1:0]                 brq_sync_r;
   logic [1:0]                 dhi_sync_r [8];
   logic [EBI_WAIT_W-1:0]      wait_r;
   ebi_req_t                   cur_r;
   logic [2:0]                 area_r;
   logic                       hit_any_r;
   logic [EBI_AREAS-1:0]       hit_vec;
   logic [2:0]                 hit_idx;
   logic                       hit_any;
   logic                       swap;
   logic                       wide;
   logic                       drive;
   logic                       done;
   logic [15:0]                rd_swapped;
   logic [7:0]                 dhi_pins;

   function automatic logic [15:0] swap16(input logic [15:0] v, input logic en);
      swap16 = en ? {v[7:0], v[15:8]} : v;
   endfunction

   ebi_clk_div u_div
   (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .bus_en_o  (bus_en),
      .bus_clk_o (div_clk)
   );

   ////////////////////////////////////////////////////////////////////////
   // Area decode, lowest index wins on overlap
   always_comb
   begin
      hit_vec = '0;
      for (int i = 0; i < EBI_AREAS; i++)
      begin
         hit_vec[i] = area_en_i[i] &&
            (((req_i.addr[EBI_ADDR_W-1:EBI_BLOCK_SHIFT] ^ area_cfg_i[i].base)
              & ~area_cfg_i[i].mask) == '0);
      end
   end

   always_comb
   begin
      hit_idx = 3'h0;
      for (int i = EBI_AREAS - 1; i >= 0; i--)
      begin
         if (hit_vec[i])
         begin
            hit_idx = 3'(i);
         end
      end
   end

   assign hit_any = |hit_vec;
   assign wide    = (width_i == EBI_WIDTH_16);
   assign swap    = le_en_i && (area_r == le_area_i) && (le_area_i != 3'h0)
                    && (le_area_i <= 3'h5);
   assign done    = (state_r == EBI_DATA) && bus_en && (wait_r == '0)
                    && rdy_sync_r[1];
   assign drive   = (state_r != EBI_GRANT);
   // Upper pins are ports in 8-bit mode, so byte reads use the lower lane
   assign rd_swapped = swap16(wide ? data_i : {8'h00, data_i[7:0]}, swap & wide);
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         dhi_pins[i] = dhi_sync_r[i][1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase machine moves only on bus-rate enables
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         EBI_IDLE:
         begin
            if (bus_en && brq_sync_r[1])
            begin
               state_nxt = EBI_GRANT;
            end
            else if (bus_en && req_valid_i)
            begin
               state_nxt = EBI_ADDR;
            end
         end
         EBI_ADDR:
         begin
            if (bus_en)
            begin
               state_nxt = EBI_DATA;
            end
         end
         EBI_DATA:
         begin
            if (done)
            begin
               state_nxt = EBI_IDLE;
            end
         end
         EBI_GRANT:
         begin
            if (bus_en && !brq_sync_r[1])
            begin
               state_nxt = EBI_IDLE;
            end
         end
         default:
         begin
            state_nxt = EBI_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdy_sync_r <= 2'h0;
         brq_sync_r <= 2'h0;
         for (int i = 0; i < 8; i++)
         begin
            dhi_sync_r[i] <= 2'h0;
         end
      end
      else
      begin
         rdy_sync_r <= {rdy_sync_r[0], ready_i};
         brq_sync_r <= {brq_sync_r[0], bus_release_request_i};
         for (int i = 0; i < 8; i++)
         begin
            dhi_sync_r[i] <= {dhi_sync_r[i][0], data_i[8 + i]};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_r   <= EBI_IDLE;
         wait_r    <= '0;
         cur_r     <= '0;
         area_r    <= 3'h0;
         hit_any_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == EBI_IDLE && state_nxt == EBI_ADDR)
         begin
            cur_r     <= req_i;
            area_r    <= hit_idx;
            hit_any_r <= hit_any;
            wait_r    <= hit_any ? area_cfg_i[hit_idx].waits : '0;
         end
         else if (state_r == EBI_DATA && bus_en && wait_r != '0)
         begin
            wait_r <= wait_r - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin registers
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         req_ready_o                 <= 1'b0;
         rsp_valid_o                 <= 1'b0;
         rsp_data_o                  <= 16'h0000;
         addr_o                      <= '0;
         addr_oe_o                   <= '0;
         data_o                      <= 16'h0000;
         data_oe_o                   <= 16'h0000;
         upper_data_port_pins_o      <= 8'h00;
         area_select_n_o             <= '1;
         area_select_oe_o            <= '0;
         read_strobe_n_o             <= 1'b1;
         rd_oe_o                     <= 1'b0;
         upper_lane_write_strobe_n_o <= 1'b1;
         upper_lane_oe_o             <= 1'b0;
         lower_lane_write_strobe_n_o <= 1'b1;
         lower_lane_oe_o             <= 1'b0;
         bus_clk_o                   <= 1'b0;
         bus_release_grant_o         <= 1'b1;
      end
      else
      begin
         req_ready_o <= (state_r == EBI_IDLE) && bus_en && !brq_sync_r[1];
         rsp_valid_o <= done;
         if (done && !cur_r.wr)
         begin
            rsp_data_o <= rd_swapped;
         end
         for (int i = 0; i < EBI_ADDR_W; i++)
         begin
            if (i >= 16 && i <= 23 && addr_port_sel_i[i-16])
            begin
               addr_o[i]    <= addr_port_out_i[i-16];
               addr_oe_o[i] <= 1'b1;
            end
            else
            begin
               addr_o[i]    <= cur_r.addr[i];
               addr_oe_o[i] <= drive;
            end
         end
         data_o    <= swap16(cur_r.wdata, swap & wide);
         data_oe_o <= {wide ? {8{drive && cur_r.wr && state_r == EBI_DATA}}
                            : data_port_oe_i,
                       {8{drive && cur_r.wr && state_r == EBI_DATA}}};
         if (!wide)
         begin
            data_o[15:8] <= data_port_out_i;
         end
         upper_data_port_pins_o <= wide ? 8'h00 : dhi_pins;
         for (int i = 0; i < EBI_AREAS; i++)
         begin
            area_select_oe_o[i] <= sel_port_sel_i[i] | drive;
            area_select_n_o[i]  <= sel_port_sel_i[i] ? sel_port_out_i[i]
               : !(hit_any_r && area_r == 3'(i)
                   && (state_r == EBI_ADDR || state_r == EBI_DATA));
         end
         // Strobes follow the next state so they cover the whole data phase
         read_strobe_n_o <= !(state_nxt == EBI_DATA && !cur_r.wr);
         rd_oe_o         <= drive;
         upper_lane_write_strobe_n_o <= !(state_nxt == EBI_DATA && cur_r.wr
            && (!wide || cur_r.half || !cur_r.byte_hi));
         upper_lane_oe_o <= drive;
         if (wide)
         begin
            lower_lane_write_strobe_n_o <= !(state_nxt == EBI_DATA && cur_r.wr
               && (cur_r.half || cur_r.byte_hi));
            lower_lane_oe_o <= drive;
         end
         else
         begin
            lower_lane_write_strobe_n_o <= lstrb_port_out_i;
            lower_lane_oe_o             <= lstrb_port_oe_i;
         end
         bus_clk_o <= clk_port_sel_i ? clk_port_out_i : div_clk;
         bus_release_grant_o <= (state_nxt != EBI_GRANT);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_start;
      state_r == EBI_IDLE && state_nxt == EBI_ADDR && area_cfg_i[hit_idx].waits == '0
      && hit_any;
   endsequence

   a_basic_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_start ##1 (ready_i && brq_sync_r[1] == brq_sync_r[1])[*6]
      |-> state_r == EBI_IDLE)
      else $error("unwaited access not finished in two bus cycles");

   a_wait_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state_r == EBI_DATA && wait_r != '0 |=> state_r == EBI_DATA)
      else $error("access ended with waits pending");

   a_ready_stall: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state_r == EBI_DATA && !rdy_sync_r[1] |=> state_r == EBI_DATA)
      else $error("access ended while not ready");

   a_grant_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state_r == EBI_GRANT |-> !bus_release_grant_o)
      else $error("grant not low while released");

   a_grant_float: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state_r == EBI_GRANT ##1 state_r == EBI_GRANT |-> !rd_oe_o && !upper_lane_oe_o)
      else $error("bus driven while granted");

   a_no_mid_grant: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state_r == EBI_DATA |=> state_r != EBI_GRANT)
      else $error("grant inside access");

   a_sel_held: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state_r == EBI_DATA && hit_any_r && !sel_port_sel_i[0] && area_r == 3'h0
      |=> !area_select_n_o[0])
      else $error("area select dropped during access");

   a_rd_strobe: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $fell(read_strobe_n_o) |-> $past(state_nxt) == EBI_DATA && !cur_r.wr)
      else $error("read strobe outside read data phase");

   a_lane_8bit: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !wide ##1 !wide |-> lower_lane_write_strobe_n_o == $past(lstrb_port_out_i))
      else $error("lower strobe not port in 8-bit mode");

endmodule

/* File: tb/ebi_mem_model.sv */
// Far-side memory with a ready line that can stretch each access
module ebi_mem_model
   import ebi_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic [EBI_ADDR_W-1:0] addr_i,
   input  wire logic [EBI_AREAS-1:0]  sel_n_i,
   input  wire logic                  rd_n_i,
   input  wire logic                  wu_n_i,
   input  wire logic                  wl_n_i,
   input  wire logic [15:0]           wdata_i,
   input  wire logic [3:0]            stall_i,
   output logic [15:0]                rdata_o,
   output logic                       ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [logic [23:0]];
   logic [15:0] last = 16'h5A5A;
   logic [3:0]  cnt  = 4'h0;
   logic        sel_d = 1'b0;
   wire  [23:0] wa   = addr_i[24:1];
   wire         act  = ~&sel_n_i;
   ////////////////////////////////////////////////////////////////////////////////
   // Ready held low for stall_i cycles from the start of a selected cycle
   always @(posedge clk_i)
   begin
      sel_d <= act;
      if (act && !sel_d)
         cnt <= stall_i;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
   assign ready_o = (cnt == 4'h0);
   ////////////////////////////////////////////////////////////////////////////////
   // Released data lines show the inverse of the last value, never a stale copy
   always @*
   begin
      if (!rd_n_i && mem.exists(wa))
         rdata_o = mem[wa];
      else
         rdata_o = ~last;
   end
   always @(posedge clk_i)
   begin
      if (!wu_n_i)
         mem[wa][15:8] = wdata_i[15:8];
      if (!wl_n_i)
         mem[wa][7:0] = wdata_i[7:0];
      if (!rd_n_i)
         last <= rdata_o;
   end
endmodule

/* File: tb/ebi_top_test.sv */
module ebi_top_test
   import ebi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  sys_clk_i = 1'b0;
   logic                  rstn_i, req_valid_i, le_en_i, clk_port_sel_i, clk_port_out_i;
   logic                  lstrb_port_out_i, lstrb_port_oe_i, ready_i, bus_release_request_i;
   ebi_req_t              req_i;
   ebi_area_cfg_t         area_cfg_i [EBI_AREAS];
   ebi_width_t            width_i;
   logic [EBI_AREAS-1:0]  area_en_i, sel_port_sel_i, sel_port_out_i;
   logic [EBI_AREAS-1:0]  area_select_n_o, area_select_oe_o;
   logic [2:0]            le_area_i;
   logic [7:0]            addr_port_sel_i, addr_port_out_i, data_port_out_i, data_port_oe_i;
   logic [7:0]            upper_data_port_pins_o;
   logic [EBI_ADDR_W-1:0] addr_o, addr_oe_o;
   logic [15:0]           data_i, data_o, data_oe_o, rsp_data_o, seed, d, exp, rdat;
   logic                  req_ready_o, rsp_valid_o, read_strobe_n_o, rd_oe_o, bus_clk_o;
   logic                  upper_lane_write_strobe_n_o, upper_lane_oe_o, bus_release_grant_o;
   logic                  lower_lane_write_strobe_n_o, lower_lane_oe_o, us, ls, rs, brk, b;
   logic [5:0]            sseen;
   logic [3:0]            stall = 4'h0;
   logic [24:0]           adr;
   int                    miscompares = 0, checks = 0, len = 0, last_len = 0, i, n, w, a;
   wire rd_a = !read_strobe_n_o && rd_oe_o;
   wire up_a = !upper_lane_write_strobe_n_o && upper_lane_oe_o;
   wire lo_a = !lower_lane_write_strobe_n_o && lower_lane_oe_o;
   wire nsel = &(area_select_n_o | ~area_select_oe_o);

   ebi_top ebi_top_inst (.*);
   ebi_mem_model ebi_mem_model_inst (.clk_i(sys_clk_i), .addr_i(addr_o), .stall_i(stall),
      .sel_n_i(area_select_n_o | ~area_select_oe_o), .rd_n_i(read_strobe_n_o | ~rd_oe_o),
      .wu_n_i(upper_lane_write_strobe_n_o | ~upper_lane_oe_o), .wdata_i(data_o),
      .wl_n_i(lower_lane_write_strobe_n_o | ~lower_lane_oe_o), .rdata_o(data_i),
      .ready_o(ready_i));

   always #20 sys_clk_i = ~sys_clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lf(input logic [15:0] s);
      lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic acc(input logic wr, input logic h, input logic bh, input logic [24:0] ad,
                      input logic [15:0] wd);
      int k;
      @(negedge sys_clk_i);
      sseen = '0;
      {us, ls, rs, brk} = 4'h0;
      @(posedge sys_clk_i);
      req_i <= '{wr: wr, half: h, byte_hi: bh, addr: ad, wdata: wd};
      req_valid_i <= 1'b1;
      k = 0;
      do
      begin
         @(posedge sys_clk_i);
         k++;
      end while (!req_ready_o && k < 100);
      // Request stays up until the answer, refused cycles are simply retried
      while (!rsp_valid_o && k < 400)
      begin
         @(posedge sys_clk_i);
         k++;
      end
      req_valid_i <= 1'b0;
      rdat = rsp_data_o;
      chk("done", 1, rsp_valid_o);
      repeat (3) @(posedge sys_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Strobe timing and select coverage seen on the pins
   always @(posedge sys_clk_i)
   begin
      if (rd_a || up_a || lo_a)
      begin
         len++;
         sseen |= ~area_select_n_o & area_select_oe_o;
         {us, ls, rs} |= {up_a, lo_a, rd_a};
         brk |= nsel;
      end
      else if (len != 0)
      begin
         last_len = len;
         len = 0;
      end
      if (!bus_release_grant_o && !nsel)
         chk("grant_busy", 0, 1);
   end

   initial
   begin
      #(40 * 20000);
      chk("watchdog", 0, 1);
      test_done;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rstn_i, req_valid_i, le_en_i, clk_port_sel_i, clk_port_out_i} = 5'h00;
      {lstrb_port_out_i, lstrb_port_oe_i, bus_release_request_i} = 3'h4;
      req_i = '0;
      width_i = EBI_WIDTH_16;
      {area_en_i, sel_port_sel_i, sel_port_out_i} = {6'h3F, 6'h00, 6'h3F};
      le_area_i = 3'h3;
      {addr_port_sel_i, addr_port_out_i, data_port_out_i, data_port_oe_i} = 32'h0000_0000;
      seed = 16'h5573;
      // Area 5 sits at the top block so address bit 24 is exercised
      for (i = 0; i < EBI_AREAS; i++)
         area_cfg_i[i] = '{base: (i == 5) ? 9'h1FF : 9'(i), mask: 9'h000, waits: 3'h0};
      repeat (10) @(posedge sys_clk_i);
      chk("rst_lstrb_oe", 0, lower_lane_oe_o);
      chk("rst_grant", 1, bus_release_grant_o);
      repeat (10) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      n = 0;
      repeat (16)
      begin
         b = bus_clk_o;
         @(posedge sys_clk_i);
         n += (b !== bus_clk_o);
      end
      chk("clk_toggles", 16, n);
      for (i = 0; i < 12; i++)
      begin
         w = i % 8;
         a = i % 6;
         seed = lf(seed);
         adr = {area_cfg_i[a].base, seed[15:1], 1'b0};
         seed = lf(seed);
         d = seed;
         exp = (i >= 6 && a == 3) ? {d[7:0], d[15:8]} : d;
         @(posedge sys_clk_i);
         area_cfg_i[a].waits <= 3'(w);
         le_en_i <= (i >= 6);
         stall <= (w == 1) ? 4'h8 : 4'h0;
         acc(1'b1, 1'b1, 1'b0, adr, d);
         chk("wr_len", (w == 1) ? 1 : 2 + 2 * w, (w == 1) ? (last_len > 4) : last_len);
         chk("wr_sel", 32'(1 << a), {brk, sseen});
         chk("wr_strb", 3'b110, {us, ls, rs});
         chk("wr_lanes", exp, ebi_mem_model_inst.mem[adr[24:1]]);
         acc(1'b0, 1'b1, 1'b0, adr, 16'h0000);
         chk("rd_len", (w == 1) ? 1 : 2 + 2 * w, (w == 1) ? (last_len > 4) : last_len);
         chk("rd_sel", 32'(1 << a), {brk, sseen});
         chk("rd_strb", 3'b001, {us, ls, rs});
         chk("rd_data", d, rdat);
      end
      stall <= 4'h0;
      acc(1'b1, 1'b0, 1'b1, adr, 16'hA5A5);
      chk("byte_strb", 3'b010, {us, ls, rs});
      chk("byte_lanes", {exp[15:8], 8'hA5}, ebi_mem_model_inst.mem[adr[24:1]]);
      width_i <= EBI_WIDTH_8;
      lstrb_port_oe_i <= 1'b1;
      acc(1'b1, 1'b0, 1'b0, adr, 16'h3C3C);
      chk("w8_strb", 3'b100, {us, ls, rs});
      chk("w8_lstrb_port", 2'b11, {lower_lane_oe_o, lower_lane_write_strobe_n_o});
      width_i <= EBI_WIDTH_16;
      lstrb_port_oe_i <= 1'b0;
      // Release requested while a read is still on the bus
      fork
         acc(1'b0, 1'b1, 1'b0, adr, 16'h0000);
         begin
            repeat (3) @(posedge sys_clk_i);
            bus_release_request_i <= 1'b1;
         end
      join
      n = 0;
      while (bus_release_grant_o && n < 50)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      chk("grant", 0, bus_release_grant_o);
      chk("float", 0, {addr_oe_o, area_select_oe_o, rd_oe_o, upper_lane_oe_o});
      req_valid_i <= 1'b1;
      n = 0;
      repeat (8)
      begin
         @(posedge sys_clk_i);
         n += req_ready_o;
      end
      chk("refused", 0, n);
      bus_release_request_i <= 1'b0;
      n = 0;
      while (!req_ready_o && n < 50)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      req_valid_i <= 1'b0;
      chk("grant_back", 1, bus_release_grant_o);
      repeat (30) @(posedge sys_clk_i);
      addr_port_sel_i <= 8'h0F;
      addr_port_out_i <= 8'hA5;
      {sel_port_sel_i, sel_port_out_i} <= {6'h20, 6'h00};
      {clk_port_sel_i, clk_port_out_i} <= 2'b11;
      repeat (4) @(posedge sys_clk_i);
      chk("addr_port", 4'h5, addr_o[19:16]);
      chk("sel_port", 0, area_select_n_o[5]);
      chk("clk_port", 1, bus_clk_o);
      test_done;
   end
endmodule
